// >>> rtl/intc_defines.svh
// Purpose: Register offsets, field positions and reset values of the interrupt controller.
// Assumes: Classic Wishbone slave with 32-bit data; registers are 16 bits in the low lanes.
// Notes:   Byte addresses are word aligned; unmapped addresses read as zero.
//
// Overview of operation
// - Every source has a sticky request flag set by hardware and cleared only by software.
// - Every source has its own enable bit that allows or blocks its requests.
// - Every user source has a writable 3-bit field choosing one of eight priority levels.
// - The winning vector number and its level are latched into one readable status register.
// - The latched level equals the assigned priority of the pending interrupt.
// - Source positions follow vector order, vector 8 on flag bit 0 and priority bits 2:0.
// - The CPU status register holds the CPU level in bits 7:5 and software may write it.
// - A read-only fourth level bit in the core control register lifts the level over traps.
// - The first global control register holds nesting disable and the trap flags.
// - The second control register gates interrupts, picks the external edge and the table.
// - A further control register holds a software hard trap bit and a double-bit error flag.
// - There are eight flag, eight enable, thirty priority and one vector status registers.
`ifndef INTC_DEFINES_SVH
`define INTC_DEFINES_SVH

// ==========================================================================
// Register byte addresses
`define ADR_CTRL_A      8'h00
`define ADR_CTRL_B      8'h04
`define ADR_CTRL_D      8'h08
`define ADR_VEC_STAT    8'h0c
`define ADR_CPU_STAT    8'h10
`define ADR_CORE_CTRL   8'h14
`define ADR_FLAG_PAGE   3'h1
`define ADR_EN_PAGE     3'h2
`define N_PRIO_REGS     5'd30

// ==========================================================================
// Field positions
`define NEST_DIS_BIT    15
`define TRAP_LO_BIT     1
`define TRAP_HI_BIT     4
`define GIE_BIT         15
`define ALT_TABLE_BIT   8
`define EXT_EDGE_BIT    0
`define SOFT_TRAP_BIT   0
`define DBE_BIT         1
`define LVL_LO_BIT      5
`define LVL_HI_BIT      7
`define LVL_MSB_BIT     3
`define VEC_BASE        8'h08

// ==========================================================================
// Write masks and reset values
`define CTRL_A_WMASK    16'h801e
`define CTRL_B_WMASK    16'h8101
`define CTRL_D_WMASK    16'h0003
`define CTRL_B_RST      16'h8000
`define PRIO_RST        3'h4
`define TOP_LEVEL       3'h7

`endif

// >>> rtl/intc_pkg.sv
// Purpose: Types shared by the interrupt controller modules.
// Assumes: 120 prioritised sources in 128 flag and enable positions.
// Notes:   The whole controller state is one packed struct.
`default_nettype none
package intc_pkg;
  localparam int N_SRC  = 120;
  localparam int N_BITS = 128;

  typedef logic [2:0]        prio_t;
  typedef prio_t [N_SRC-1:0] prio_vec_t;

  typedef struct packed {
    logic [N_BITS-1:0] flag;
    logic [N_BITS-1:0] en;
    prio_vec_t         prio;
    logic [15:0]       ctrl_a;
    logic [15:0]       ctrl_b;
    logic [15:0]       ctrl_d;
    logic [2:0]        cpu_lvl;
    logic              lvl_msb;
    logic [7:0]        vec;
    logic [3:0]        lvl;
    logic              valid;
    logic              ack;
    logic [15:0]       rdata;
    logic [1:0]        ext_sync;
    logic              ext_prev;
  } state_t;
endpackage : intc_pkg
`default_nettype wire

// >>> rtl/intc_arbiter.sv
// Purpose: Picks the highest-priority pending source above the CPU level.
// Assumes: Inputs come from registers on the same clock.
// Notes:   Pure combinational; a linear scan keeps it small at the cost of depth.
`default_nettype none
module intc_arbiter
  import intc_pkg::*;
(
  input  wire logic [N_SRC-1:0] pend,
  input  wire intc_pkg::prio_vec_t prio,
  input  wire logic [3:0]       cur_lvl,
  output logic                  found,
  output logic [6:0]            win_idx,
  output logic [2:0]            win_prio
);

  // Scan from the top so that an equal level at a lower index replaces the winner.
  always_comb begin
    found    = 1'b0;
    win_idx  = 7'h00;
    win_prio = 3'h0;
    for (int i = N_SRC - 1; i >= 0; i--) begin
      if (pend[i] && ({1'b0, prio[i]} > cur_lvl) && (!found || prio[i] >= win_prio)) begin
        found    = 1'b1;
        win_idx  = 7'(i);
        win_prio = prio[i];
      end
    end
  end

endmodule : intc_arbiter
`default_nettype wire

// >>> rtl/intc_top.sv
// Purpose: Prioritised interrupt controller with Wishbone register access.
// Assumes: Peripheral request pulses are on clk_sys; the external request is an async pin.
// Notes:   Flags, trap flags and error flags are sticky; a hardware set beats a software clear.
//
// Decided for this implementation: the Wishbone register port and the address map.
`include "intc_defines.svh"
`default_nettype none
module intc_top
  import intc_pkg::*;
(
  input  wire logic                clk_sys,
  input  wire logic                nrst,
  input  wire logic                wb_cyc_i,
  input  wire logic                wb_stb_i,
  input  wire logic                wb_we_i,
  input  wire logic [7:0]          wb_adr_i,
  input  wire logic [3:0]          wb_sel_i,
  input  wire logic [31:0]         wb_dat_i,
  output logic [31:0]              wb_dat_o,
  output logic                     wb_ack_o,
  input  wire logic [N_SRC-1:1]    src_req,
  input  wire logic                external_request_zero,
  input  wire logic [3:0]          trap_evt,
  input  wire logic                double_bit_error_trap,
  input  wire logic                cpu_ack,
  input  wire logic                cpu_trap_ack,
  input  wire logic                cpu_trap_exit,
  output logic                     irq_req,
  output logic [7:0]               pending_vector_number,
  output logic [3:0]               pending_priority_level,
  output logic                     trap_req,
  output logic                     nesting_disable,
  output logic                     alternate_vector_table
);
  import intc_pkg::*;

  // ==========================================================================
  // State and decode
  state_t            st_q;
  state_t            st_d;
  logic              found;
  logic [6:0]        win_idx;
  logic [2:0]        win_prio;
  logic [3:0]        eff_lvl;
  logic [N_SRC-1:0]  pend;
  logic [N_BITS-1:0] set_vec;
  logic              ext_edge;
  logic              bus_req;
  logic              wr_hit;
  logic [15:0]       wmask;
  logic [15:0]       rd_word;
  logic              is_flag;
  logic              is_en;
  logic              is_prio;
  logic [4:0]        prio_reg;

  // Bus access steps: the write lands on the edge that carries the acknowledge.
  assign bus_req  = wb_cyc_i && wb_stb_i;
  assign wr_hit   = bus_req && wb_we_i && st_q.ack;
  assign wmask    = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  assign is_flag  = (wb_adr_i[7:5] == `ADR_FLAG_PAGE);
  assign is_en    = (wb_adr_i[7:5] == `ADR_EN_PAGE);
  assign prio_reg = wb_adr_i[6:2];
  assign is_prio  = wb_adr_i[7] && (prio_reg < `N_PRIO_REGS);

  // The fourth level bit sits above the three software bits.
  assign eff_lvl  = {st_q.lvl_msb, st_q.cpu_lvl};
  assign pend     = st_q.flag[N_SRC-1:0] & st_q.en[N_SRC-1:0];

  // Edge of the synchronised external pin; the control bit picks the falling edge.
  assign ext_edge = st_q.ctrl_b[`EXT_EDGE_BIT] ?
                    (st_q.ext_prev && !st_q.ext_sync[1]) :
                    (!st_q.ext_prev && st_q.ext_sync[1]);
  assign set_vec  = {{(N_BITS - N_SRC){1'b0}}, src_req, ext_edge};

  intc_arbiter u_arb (
    .pend     (pend),
    .prio     (st_q.prio),
    .cur_lvl  (eff_lvl),
    .found    (found),
    .win_idx  (win_idx),
    .win_prio (win_prio)
  );

  // ==========================================================================
  // Read multiplexer; unmapped addresses answer with zero.
  always_comb begin
    rd_word = 16'h0000;
    if (is_flag) begin
      rd_word = st_q.flag[{wb_adr_i[4:2], 4'h0} +: 16];
    end else if (is_en) begin
      rd_word = st_q.en[{wb_adr_i[4:2], 4'h0} +: 16];
    end else if (is_prio) begin
      for (int f = 0; f < 4; f++) begin
        rd_word[f*4 +: 3] = st_q.prio[int'(prio_reg) * 4 + f];
      end
    end else begin
      case (wb_adr_i)
        `ADR_CTRL_A:    rd_word = st_q.ctrl_a;
        `ADR_CTRL_B:    rd_word = st_q.ctrl_b;
        `ADR_CTRL_D:    rd_word = st_q.ctrl_d;
        `ADR_VEC_STAT:  rd_word = {4'h0, st_q.lvl, st_q.vec};
        `ADR_CPU_STAT:  rd_word = {8'h00, st_q.cpu_lvl, 5'h00};
        `ADR_CORE_CTRL: rd_word = {12'h000, st_q.lvl_msb, 3'h0};
        default:        rd_word = 16'h0000;
      endcase
    end
  end

  // ==========================================================================
  // Next state: bus writes first, hardware sets last so that they win.
  always_comb begin
    st_d     = st_q;
    st_d.ack = bus_req && !st_q.ack;
    if (bus_req && !st_q.ack) begin
      st_d.rdata = rd_word;
    end

    // Pin synchroniser; the first stage feeds only the second.
    st_d.ext_sync = {st_q.ext_sync[0], external_request_zero};
    st_d.ext_prev = st_q.ext_sync[1];

    if (wr_hit) begin
      if (is_flag) begin
        st_d.flag[{wb_adr_i[4:2], 4'h0} +: 16] =
          (st_q.flag[{wb_adr_i[4:2], 4'h0} +: 16] & ~wmask) | (wb_dat_i[15:0] & wmask);
      end else if (is_en) begin
        st_d.en[{wb_adr_i[4:2], 4'h0} +: 16] =
          (st_q.en[{wb_adr_i[4:2], 4'h0} +: 16] & ~wmask) | (wb_dat_i[15:0] & wmask);
      end else if (is_prio) begin
        for (int f = 0; f < 4; f++) begin
          if (wb_sel_i[f / 2]) begin
            st_d.prio[int'(prio_reg) * 4 + f] = wb_dat_i[f*4 +: 3];
          end
        end
      end else begin
        case (wb_adr_i)
          `ADR_CTRL_A: st_d.ctrl_a = (st_q.ctrl_a & ~(wmask & `CTRL_A_WMASK)) |
                                     (wb_dat_i[15:0] & wmask & `CTRL_A_WMASK);
          `ADR_CTRL_B: st_d.ctrl_b = (st_q.ctrl_b & ~(wmask & `CTRL_B_WMASK)) |
                                     (wb_dat_i[15:0] & wmask & `CTRL_B_WMASK);
          `ADR_CTRL_D: st_d.ctrl_d = (st_q.ctrl_d & ~(wmask & `CTRL_D_WMASK)) |
                                     (wb_dat_i[15:0] & wmask & `CTRL_D_WMASK);
          `ADR_CPU_STAT: begin
            if (wb_sel_i[0]) begin
              st_d.cpu_lvl = wb_dat_i[`LVL_HI_BIT:`LVL_LO_BIT];
            end
          end
          default: st_d.cpu_lvl = st_q.cpu_lvl;
        endcase
      end
    end

    // Hardware event sets override a same-cycle software clear.
    st_d.flag = st_d.flag | set_vec;
    st_d.ctrl_a[`TRAP_HI_BIT:`TRAP_LO_BIT] = st_d.ctrl_a[`TRAP_HI_BIT:`TRAP_LO_BIT] | trap_evt;
    if (double_bit_error_trap) begin
      st_d.ctrl_d[`DBE_BIT] = 1'b1;
    end

    // Accepting a vector raises the CPU level; with nesting off it goes to the top.
    if (cpu_ack && st_q.valid) begin
      st_d.cpu_lvl = st_q.ctrl_a[`NEST_DIS_BIT] ? `TOP_LEVEL : st_q.lvl[2:0];
    end

    // The fourth level bit changes only by trap entry and exit, never by software.
    if (cpu_trap_ack) begin
      st_d.lvl_msb = 1'b1;
    end else if (cpu_trap_exit) begin
      st_d.lvl_msb = 1'b0;
    end

    // Latch the current winner; an empty field means no pending source is above the CPU level.
    st_d.valid = found;
    st_d.vec   = found ? (8'(win_idx) + `VEC_BASE) : 8'h00;
    st_d.lvl   = found ? {1'b0, win_prio} : 4'h0;
  end

  // ==========================================================================
  // State register with synchronous reset.
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      st_q        <= '0;
      st_q.ctrl_b <= `CTRL_B_RST;
      st_q.prio   <= {N_SRC{`PRIO_RST}};
    end else begin
      st_q <= st_d;
    end
  end

  // Outputs; only the request is gated by the global enable.
  assign wb_dat_o               = {16'h0000, st_q.rdata};
  assign wb_ack_o               = st_q.ack;
  assign irq_req                = st_q.valid && st_q.ctrl_b[`GIE_BIT];
  assign pending_vector_number  = st_q.vec;
  assign pending_priority_level = st_q.lvl;
  assign trap_req               = (|st_q.ctrl_a[`TRAP_HI_BIT:`TRAP_LO_BIT]) ||
                                  st_q.ctrl_d[`SOFT_TRAP_BIT] || st_q.ctrl_d[`DBE_BIT];
  assign nesting_disable        = st_q.ctrl_a[`NEST_DIS_BIT];
  assign alternate_vector_table = st_q.ctrl_b[`ALT_TABLE_BIT];

  // ==========================================================================
  // Checks on the controller's own behaviour.
  a_flag_stays_set: assert property (@(posedge clk_sys) disable iff (!nrst)
    st_q.flag[3] && !(wr_hit && is_flag) |=> st_q.flag[3])
    else $error("request flag dropped without a software write");

  a_source_sets_flag: assert property (@(posedge clk_sys) disable iff (!nrst)
    src_req[5] |=> st_q.flag[5])
    else $error("source event did not set its flag");

  a_vector_in_range: assert property (@(posedge clk_sys) disable iff (!nrst)
    st_q.valid |-> (st_q.vec >= 8'h08) && (st_q.vec < 8'h80))
    else $error("latched vector number out of range");

  // A priority write reaches the latched level one cycle late, so that cycle is skipped.
  a_level_matches_prio: assert property (@(posedge clk_sys) disable iff (!nrst)
    st_q.valid && $stable(st_q.prio) |-> st_q.lvl == {1'b0, st_q.prio[st_q.vec - 8'h08]})
    else $error("latched level differs from source priority");

  a_zero_prio_silent: assert property (@(posedge clk_sys) disable iff (!nrst)
    st_q.valid |-> st_q.lvl != 4'h0)
    else $error("priority zero source won arbitration");

  a_above_cpu_level: assert property (@(posedge clk_sys) disable iff (!nrst)
    found |=> st_q.valid && (st_q.lvl > $past(eff_lvl)))
    else $error("winner not above the cpu level");

  a_msb_read_only: assert property (@(posedge clk_sys) disable iff (!nrst)
    !cpu_trap_ack && !cpu_trap_exit |=> st_q.lvl_msb == $past(st_q.lvl_msb))
    else $error("fourth level bit changed without a trap");

  a_cpu_level_write: assert property (@(posedge clk_sys) disable iff (!nrst)
    wr_hit && wb_adr_i == `ADR_CPU_STAT && wb_sel_i[0] && !cpu_ack
    |=> st_q.cpu_lvl == $past(wb_dat_i[7:5]))
    else $error("cpu level write not taken");

  a_dbe_sticky: assert property (@(posedge clk_sys) disable iff (!nrst)
    double_bit_error_trap |=> st_q.ctrl_d[1] ##1 (st_q.ctrl_d[1] || $past(wr_hit)))
    else $error("double-bit error flag not held");

  a_gie_gates_req: assert property (@(posedge clk_sys) disable iff (!nrst)
    !st_q.ctrl_b[15] |-> !irq_req)
    else $error("request raised while globally disabled");

  a_ack_one_cycle: assert property (@(posedge clk_sys) disable iff (!nrst)
    wb_ack_o |=> !wb_ack_o)
    else $error("bus acknowledge longer than one cycle");

  // ==========================================================================
  // Checks on the bus, arbitration, level tracking and trap reporting. Every field is registered,
  // so an event that lands in one cycle is looked for in the next.
  a_ack_follows_req: assert property (@(posedge clk_sys) disable iff (!nrst)
    bus_req && !wb_ack_o |=> wb_ack_o)
    else $error("bus request not acknowledged in the next cycle");

  a_nest_top_level: assert property (@(posedge clk_sys) disable iff (!nrst)
    cpu_ack && st_q.valid && st_q.ctrl_a[`NEST_DIS_BIT] |=> st_q.cpu_lvl == `TOP_LEVEL)
    else $error("nesting disabled but cpu level not raised to the top");

  a_nest_takes_level: assert property (@(posedge clk_sys) disable iff (!nrst)
    cpu_ack && st_q.valid && !st_q.ctrl_a[`NEST_DIS_BIT] |=> st_q.cpu_lvl == $past(st_q.lvl[2:0]))
    else $error("accepted vector did not set the cpu level");

  a_trap_flag_set: assert property (@(posedge clk_sys) disable iff (!nrst)
    trap_evt[0] |=> st_q.ctrl_a[`TRAP_LO_BIT])
    else $error("trap event did not set its flag");

  a_soft_trap_req: assert property (@(posedge clk_sys) disable iff (!nrst)
    st_q.ctrl_d[`SOFT_TRAP_BIT] |-> trap_req)
    else $error("software hard trap not reported");

  a_dbe_raises_trap: assert property (@(posedge clk_sys) disable iff (!nrst)
    st_q.ctrl_d[`DBE_BIT] |-> trap_req)
    else $error("double-bit error flag not reported as a trap");

  a_idle_vector_zero: assert property (@(posedge clk_sys) disable iff (!nrst)
    !st_q.valid |-> (st_q.vec == 8'h00) && (st_q.lvl == 4'h0))
    else $error("vector status not empty while nothing is pending");

  a_msb_set_by_trap: assert property (@(posedge clk_sys) disable iff (!nrst)
    cpu_trap_ack |=> st_q.lvl_msb)
    else $error("trap entry did not set the fourth level bit");

  a_masked_no_winner: assert property (@(posedge clk_sys) disable iff (!nrst)
    st_q.lvl_msb |-> !found)
    else $error("source won while the fourth level bit was set");

  a_ext_pin_sets: assert property (@(posedge clk_sys) disable iff (!nrst)
    ext_edge |=> st_q.flag[0])
    else $error("external pin edge did not set its flag");

  a_disabled_not_pending: assert property (@(posedge clk_sys) disable iff (!nrst)
    !st_q.en[5] |-> !(found && (win_idx == 7'd5)))
    else $error("disabled source won arbitration");

  a_write_lands: assert property (@(posedge clk_sys) disable iff (!nrst)
    wr_hit && is_en && (wb_adr_i[4:2] == 3'h0) && wb_sel_i[0] |=> st_q.en[0] == $past(wb_dat_i[0]))
    else $error("enable write not taken");

  a_gie_passes_req: assert property (@(posedge clk_sys) disable iff (!nrst)
    st_q.ctrl_b[`GIE_BIT] && st_q.valid |-> irq_req)
    else $error("pending vector not requested while globally enabled");

  a_tie_low_vector: assert property (@(posedge clk_sys) disable iff (!nrst)
    found && pend[3] && pend[5] && (st_q.prio[3] == st_q.prio[5]) &&
    ({1'b0, st_q.prio[3]} > eff_lvl) |-> win_idx != 7'd5)
    else $error("higher vector won a priority tie");

endmodule : intc_top
`default_nettype wire

// >>> dv/core_model.sv
// Purpose: Behavioural processor core facing the interrupt controller.
// Assumes: Acknowledge pulses are one clk_sys cycle wide.
// Notes:   Answers only while auto_ack is high, so the bench decides when the core reacts.
`default_nettype none
module core_model #(
  parameter int ACK_DELAY = 3
) (
  input  wire logic clk_sys,
  input  wire logic nrst,
  input  wire logic irq_req,
  input  wire logic trap_req,
  input  wire logic auto_ack,
  output logic      cpu_ack,
  output logic      cpu_trap_ack,
  output logic      cpu_trap_exit
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] wait_q;
  logic       trap_q;

  // ==========================================================================
  // Core reaction
  // The wait restarts after each accept, so a request that is still visible
  // while the raised level settles is not accepted twice.
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      cpu_ack       <= 1'b0;
      cpu_trap_ack  <= 1'b0;
      cpu_trap_exit <= 1'b0;
      wait_q        <= 4'h0;
      trap_q        <= 1'b0;
    end else begin
      cpu_ack       <= 1'b0;
      cpu_trap_ack  <= auto_ack && trap_req && !trap_q;
      cpu_trap_exit <= auto_ack && !trap_req && trap_q;
      trap_q        <= trap_req;
      if (auto_ack && irq_req && !cpu_ack) begin
        if (wait_q == 4'(ACK_DELAY)) begin
          cpu_ack <= 1'b1;
          wait_q  <= 4'h0;
        end else begin
          wait_q <= wait_q + 4'h1;
        end
      end else begin
        wait_q <= 4'h0;
      end
    end
  end
endmodule : core_model
`default_nettype wire

// >>> dv/test_prioritized_interrupt_controller.sv
// Purpose: Self-checking bench for the prioritised interrupt controller.
// Assumes: Wishbone answers after one cycle; the bench still waits for ack.
// Notes:   Expected values come from the register map, not from the design.
`default_nettype none
module test_prioritized_interrupt_controller;
  timeunit 1ns;
  timeprecision 1ps;
  import intc_pkg::*;
  logic              clk_sys = 1'b0;
  logic              nrst    = 1'b0;
  logic              wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0]        wb_adr_i = 8'h00;
  logic [3:0]        wb_sel_i = 4'h0;
  logic [31:0]       wb_dat_i = 32'h0, wb_dat_o;
  logic              wb_ack_o, irq_req, trap_req, nesting_disable, alternate_vector_table;
  logic [N_SRC-1:1]  src_req = '0;
  logic              external_request_zero = 1'b0, double_bit_error_trap = 1'b0;
  logic [3:0]        trap_evt = 4'h0, pending_priority_level;
  logic [7:0]        pending_vector_number;
  logic              cpu_ack, cpu_trap_ack, cpu_trap_exit, auto_ack = 1'b0;
  int                n_fail = 0, checks_done = 0, cycles = 0;

  always #12.5 clk_sys = ~clk_sys;

  intc_top uut (.clk_sys(clk_sys), .nrst(nrst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .src_req(src_req),
    .external_request_zero(external_request_zero), .trap_evt(trap_evt),
    .double_bit_error_trap(double_bit_error_trap), .cpu_ack(cpu_ack),
    .cpu_trap_ack(cpu_trap_ack), .cpu_trap_exit(cpu_trap_exit), .irq_req(irq_req),
    .pending_vector_number(pending_vector_number),
    .pending_priority_level(pending_priority_level), .trap_req(trap_req),
    .nesting_disable(nesting_disable), .alternate_vector_table(alternate_vector_table));

  core_model core (.clk_sys(clk_sys), .nrst(nrst), .irq_req(irq_req), .trap_req(trap_req),
    .auto_ack(auto_ack), .cpu_ack(cpu_ack), .cpu_trap_ack(cpu_trap_ack),
    .cpu_trap_exit(cpu_trap_exit));

  // ==========================================================================
  // Reporting
  task automatic results;
    if (n_fail == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : results

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  // A hung handshake would otherwise stall the run forever.
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      results();
    end
  end

  // ==========================================================================
  // Bus cycles
  task automatic wb_cycle(input logic we, input logic [7:0] a, input logic [31:0] d,
                          output logic [31:0] q);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'h3;
    @(posedge clk_sys);
    while (wb_ack_o !== 1'b1) @(posedge clk_sys);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_sys);
  endtask : wb_cycle

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic [31:0] q;
    wb_cycle(1'b1, a, {16'h0, d}, q);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    wb_cycle(1'b0, a, 32'h0, q);
    check(q, exp);
  endtask : rd

  task automatic pulse_src(input int i);
    src_req[i] <= 1'b1;
    @(posedge clk_sys);
    src_req[i] <= 1'b0;
    repeat (3) @(posedge clk_sys);
  endtask : pulse_src

  // ==========================================================================
  // Main sequence
  initial begin
    repeat (6) @(posedge clk_sys);
    nrst <= 1'b1;
    @(posedge clk_sys);
    rd(8'h04, 32'h8000);
    rd(8'h80, 32'h4444);
    rd(8'h0c, 32'h0);
    rd(8'hfc, 32'h0);
    rd(8'hf8, 32'h0);
    wr(8'hf4, 16'h7777);
    rd(8'hf4, 32'h7777);
    wr(8'h3c, 16'h8000);
    rd(8'h3c, 32'h8000);
    wr(8'h3c, 16'h0);
    pulse_src(5);
    rd(8'h20, 32'h0020);
    rd(8'h0c, 32'h0);
    wr(8'h40, 16'h0020);
    rd(8'h0c, 32'h040d);
    check({31'h0, irq_req}, 32'h1);
    check({24'h0, pending_vector_number}, 32'h0000000d);
    check({28'h0, pending_priority_level}, 32'h4);
    pulse_src(3);
    wr(8'h40, 16'h0028);
    rd(8'h0c, 32'h040b);
    wr(8'h84, 16'h4464);
    rd(8'h0c, 32'h060d);
    wr(8'h10, 16'h00a0);
    rd(8'h10, 32'h00a0);
    rd(8'h0c, 32'h060d);
    wr(8'h84, 16'h4454);
    rd(8'h0c, 32'h0);
    wr(8'h10, 16'h0);
    wr(8'h84, 16'h4404);
    wr(8'h80, 16'h0444);
    rd(8'h0c, 32'h0);
    rd(8'h20, 32'h0028);
    wr(8'h80, 16'h4444);
    wr(8'h84, 16'h4474);
    // Global enable off must gate the request but not the latched vector.
    wr(8'h04, 16'h0100);
    check({31'h0, alternate_vector_table}, 32'h1);
    check({31'h0, irq_req}, 32'h0);
    rd(8'h0c, 32'h070d);
    wr(8'h04, 16'h8000);
    auto_ack <= 1'b1;
    repeat (12) @(posedge clk_sys);
    auto_ack <= 1'b0;
    rd(8'h10, 32'h00e0);
    rd(8'h0c, 32'h0);
    wr(8'h10, 16'h0);
    wr(8'h84, 16'h4424);
    wr(8'h00, 16'h8000);
    check({31'h0, nesting_disable}, 32'h1);
    rd(8'h0c, 32'h040b);
    auto_ack <= 1'b1;
    repeat (12) @(posedge clk_sys);
    auto_ack <= 1'b0;
    rd(8'h10, 32'h00e0);
    wr(8'h00, 16'h0);
    wr(8'h10, 16'h0);
    wr(8'h20, 16'h0);
    trap_evt <= 4'hf;
    @(posedge clk_sys);
    trap_evt <= 4'h0;
    rd(8'h00, 32'h001e);
    check({31'h0, trap_req}, 32'h1);
    wr(8'h00, 16'h0);
    rd(8'h00, 32'h0);
    auto_ack <= 1'b1;
    wr(8'h08, 16'h0001);
    repeat (4) @(posedge clk_sys);
    rd(8'h14, 32'h0008);
    wr(8'h14, 16'h0);
    rd(8'h14, 32'h0008);
    wr(8'h08, 16'h0);
    repeat (4) @(posedge clk_sys);
    rd(8'h14, 32'h0);
    auto_ack <= 1'b0;
    double_bit_error_trap <= 1'b1;
    @(posedge clk_sys);
    double_bit_error_trap <= 1'b0;
    rd(8'h08, 32'h0002);
    external_request_zero <= 1'b1;
    repeat (6) @(posedge clk_sys);
    rd(8'h20, 32'h0001);
    // Falling-edge mode: switching with the pin steady high must not set the flag.
    wr(8'h20, 16'h0);
    wr(8'h04, 16'h8001);
    rd(8'h20, 32'h0);
    external_request_zero <= 1'b0;
    repeat (6) @(posedge clk_sys);
    rd(8'h20, 32'h0001);
    results();
  end
endmodule : test_prioritized_interrupt_controller
`default_nettype wire
